// >>> bench/usbi_host.sv
// host side of the bus: puts J, K or SE0 on the two data lines
`timescale 1ns/10ps
`default_nettype none
module usbi_host (
	input  wire logic [1:0] st,
	output wire logic       dp,
	output wire logic       dm
);
	// state 0 idle J, 1 K, 2 SE0; no pull state, lines always driven
	assign dp = (st == 2'h0);
	assign dm = (st == 2'h1);
endmodule // usbi_host
`default_nettype wire

// >>> bench/usbi_top_asserts.sv
// checker of the usb interrupt source flags
`timescale 1ns/10ps
`default_nettype none
module usbi_top_asserts #(
	parameter SUSP_CYCLES = 20
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        usb_module_enable,
	input wire logic        resume_interrupt_enable,
	input wire logic        ep1_xfer_error,
	input wire logic        ep2_buf1_ready,
	input wire logic        control_endpoint_10_source_setup_ready,
	input wire logic        endpoint_11_source_buf0_wr_ready,
	input wire logic [6:0]  source_clear,
	input wire logic        endpoint_1_source,
	input wire logic        suspend_source,
	input wire logic        resume_source,
	input wire logic [16:0] cause_flags,
	input wire logic        bus_in_j
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [17:0] idle_q;
	wire         idle_w = bus_in_j && usb_module_enable && !reset;
	// counts edges of enabled synced J, zeroed on any break
	always @(posedge clk)
		idle_q <= idle_w ? idle_q + 18'h1 : 18'h0;
	ep1_error_a: assert property (
		ep1_xfer_error |=> endpoint_1_source && cause_flags[2])
		else $error("ep1 error lost");
	ep2_ready_a: assert property (ep2_buf1_ready |=> cause_flags[4])
		else $error("ep2 ready lost");
	setup_ready_a: assert property (
		control_endpoint_10_source_setup_ready |=> cause_flags[12])
		else $error("setup ready lost");
	endpoint_11_source_cause_a: assert property (
		$rose(cause_flags[14]) |-> $past(endpoint_11_source_buf0_wr_ready))
		else $error("endpoint_11_source flag without event");
	idle_time_a: assert property (
		$rose(suspend_source) |->
		idle_q inside {[SUSP_CYCLES - 1:SUSP_CYCLES + 1]})
		else $error("suspend at wrong idle count");
	resume_gate_a: assert property (
		$rose(resume_source) |->
		$past(usb_module_enable && resume_interrupt_enable))
		else $error("resume while disabled");
	leave_j_a: assert property (
		$fell(bus_in_j) && usb_module_enable && resume_interrupt_enable
		|-> ##[0:2] resume_source)
		else $error("resume missed");
	flag_hold_a: assert property (
		endpoint_1_source && !source_clear[0] |=> endpoint_1_source)
		else $error("flag dropped");
	cover property ($rose(suspend_source));
	cover property ($rose(resume_source));
	cover property (ep1_xfer_error && source_clear[0]);
endmodule // usbi_top_asserts
bind usbi_top usbi_top_asserts #(.SUSP_CYCLES(SUSP_CYCLES)) u_chk (
	.clk, .reset, .usb_module_enable, .resume_interrupt_enable,
	.ep1_xfer_error, .ep2_buf1_ready, .control_endpoint_10_source_setup_ready,
	.endpoint_11_source_buf0_wr_ready, .source_clear, .endpoint_1_source,
	.suspend_source, .resume_source, .cause_flags, .bus_in_j);
`default_nettype wire

// >>> bench/usbi_top_tb.sv
// self-checking bench for the usb interrupt source block
`timescale 1ns/10ps
`default_nettype none
module usbi_top_tb;
	localparam SC = 20;
	logic        clk, reset, en, rie;
	logic [1:0]  st;
	logic [14:0] ev;
	logic [6:0]  clr;
	wire  [6:0]  src;
	wire  [16:0] cf;
	wire         dp, dm, bj;
	int          num_errors, n_tests;
	usbi_host u_host (.st(st), .dp(dp), .dm(dm));
	usbi_top #(.SUSP_CYCLES(SC)) u_dut (.clk(clk), .reset(reset),
		.usb_module_enable(en), .resume_interrupt_enable(rie),
		.bus_plus_line(dp), .bus_minus_line(dm),
		.ep1_buf0_ready(ev[0]), .ep1_buf1_ready(ev[1]),
		.ep1_xfer_error(ev[2]), .ep2_buf0_ready(ev[3]),
		.ep2_buf1_ready(ev[4]), .ep2_xfer_error(ev[5]),
		.ep3_buf0_ready(ev[6]), .ep3_buf1_ready(ev[7]),
		.ep3_xfer_error(ev[8]), .control_endpoint_10_source_buf_ready(ev[9]),
		.control_endpoint_10_source_ctl_done(ev[10]), .control_endpoint_10_source_status_stage(ev[11]),
		.control_endpoint_10_source_setup_ready(ev[12]), .control_endpoint_10_source_ctl_error(ev[13]),
		.endpoint_11_source_buf0_wr_ready(ev[14]), .source_clear(clr),
		.endpoint_1_source(src[0]), .endpoint_2_source(src[1]),
		.endpoint_3_source(src[2]), .control_endpoint_10_source(src[3]),
		.endpoint_11_source(src[4]), .suspend_source(src[5]),
		.resume_source(src[6]), .cause_flags(cf), .bus_in_j(bj));
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'h1) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task end_sim;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// each event alone, then against its clear: set must win
	task t_eps;
		int          s;
		logic [23:0] x;
		for (int i = 0; i < 15; i++) begin
			s = (i < 9) ? i / 3 : (i < 14) ? 3 : 4;
			x = {17'h1 << i, 7'h1 << s};
			ev[i] = 1'h1;
			cyc(1);
			ev = 15'h0;
			cyc(2);
			chk({cf, src} === x, "set");
			clr[s] = 1'h1;
			ev[i] = 1'h1;
			cyc(1);
			ev = 15'h0;
			chk(cf[i] === 1'h1 && src[s] === 1'h1, "set vs clear");
			cyc(1);
			clr = 7'h0;
			chk({cf, src} === 24'h0, "clear");
		end
	endtask
	// a K blip must restart the idle count
	task t_susp;
		int n;
		cyc(3 * SC);
		chk(src[5] === 1'h0, "suspend while off");
		chk(bj === 1'h1, "idle bus not seen as j");
		en = 1'h1;
		cyc(SC - 4);
		st = 2'h1;
		cyc(3);
		chk(src === 7'h0, "resume gating");
		chk(bj === 1'h0, "k not seen");
		st = 2'h0;
		n = 0;
		while (src[5] !== 1'h1 && n < 3 * SC) begin
			cyc(1);
			n++;
		end
		chk(n >= SC + 2 && n <= SC + 3, "suspend time");
		clr[5] = 1'h1;
		cyc(1);
		clr = 7'h0;
		cyc(2 * SC);
		chk(src[5] === 1'h0, "second suspend");
	endtask
	task t_res;
		rie = 1'h1;
		for (int k = 1; k < 3; k++) begin
			st = 2'h0;
			clr = 7'h7f;
			cyc(4);
			clr = 7'h0;
			st = k[1:0];
			cyc(4);
			chk(src[6] === 1'h1, "resume");
		end
		// module off: leaving j must not flag resume
		st = 2'h0;
		clr = 7'h7f;
		en = 1'h0;
		cyc(4);
		clr = 7'h0;
		st = 2'h1;
		cyc(4);
		chk(src[6] === 1'h0, "resume while off");
	endtask
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		num_errors = 0;
		n_tests = 0;
		reset = 1'h1;
		{en, rie, st, ev, clr} = 26'h0;
		cyc(3);
		reset = 1'h0;
		cyc(1);
		t_eps;
		t_susp;
		t_res;
		end_sim;
	end
endmodule // usbi_top_tb
`default_nettype wire

// >>> hdl/usbi_map.vh
// constants and bit layout of the usb device interrupt source block
`ifndef USBI_MAP_VH
`define USBI_MAP_VH

// suspend idle time and clock rate
`define USBI_SUSP_IDLE_US   3000
`define USBI_CLK_MHZ        20
`define USBI_SUSP_CYCLES    (`USBI_SUSP_IDLE_US * `USBI_CLK_MHZ)
`define USBI_IDLE_W         18

// cause vector widths
`define USBI_EP_CAUSES      3
`define USBI_CTL_CAUSES     5
`define USBI_NUM_SOURCES    7
`define USBI_NUM_CAUSES     17

// positions of each group in the cause vector
`define USBI_EP1_LSB        0
`define USBI_EP2_LSB        3
`define USBI_EP3_LSB        6
`define USBI_CONTROL_ENDPOINT_10_SOURCE_LSB       9
`define USBI_ENDPOINT_11_SOURCE_BIT       14
`define USBI_SUS_BIT        15
`define USBI_RSM_BIT        16

// order of bits within an endpoint cause group
`define USBI_EP_B0_READY    0
`define USBI_EP_B1_READY    1
`define USBI_EP_XFER_ERR    2

// order of bits within the control endpoint cause group
`define USBI_CTL_BUF_READY  0
`define USBI_CTL_DONE       1
`define USBI_CTL_STATUS     2
`define USBI_CTL_SETUP_RDY  3
`define USBI_CTL_ERR        4

// order of source clear bits
`define USBI_SRC_EP1        0
`define USBI_SRC_EP2        1
`define USBI_SRC_EP3        2
`define USBI_SRC_CONTROL_ENDPOINT_10_SOURCE       3
`define USBI_SRC_ENDPOINT_11_SOURCE       4
`define USBI_SRC_SUS        5
`define USBI_SRC_RSM        6

// reset value of every flag
`define USBI_FLAG_RST       17'h00000
`define USBI_SRC_RST        7'h00

`endif

// >>> hdl/usbi_sticky.v
// bank of sticky event flags with set winning over clear
`timescale 1ns/10ps
`default_nettype none
module usbi_sticky #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         reset,
	input  wire [W-1:0] set_in,
	input  wire [W-1:0] clr_in,
	output wire [W-1:0] flag
);
	reg [W-1:0] flag_q;
	wire [W-1:0] flag_d;

	// an event in the clearing cycle must not be lost
	assign flag_d = set_in | (flag_q & ~clr_in);

	always @(posedge clk) begin
		if (reset) begin
			flag_q <= {W{1'h0}};
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag = flag_q;
endmodule // usbi_sticky
`default_nettype wire

// >>> hdl/usbi_top.v
// usb device interrupt sources: endpoint events and bus suspend/resume
`timescale 1ns/10ps
`default_nettype none
`include "usbi_map.vh"
module usbi_top #(
	parameter SUSP_CYCLES = `USBI_SUSP_CYCLES
) (
	input  wire        clk,
	input  wire        reset,
	// enables from the device's control logic
	input  wire        usb_module_enable,
	input  wire        resume_interrupt_enable,
	// raw bus pins, asynchronous to clk
	input  wire        bus_plus_line,
	input  wire        bus_minus_line,
	// endpoint 1 event pulses
	input  wire        ep1_buf0_ready,
	input  wire        ep1_buf1_ready,
	input  wire        ep1_xfer_error,
	// endpoint 2 event pulses
	input  wire        ep2_buf0_ready,
	input  wire        ep2_buf1_ready,
	input  wire        ep2_xfer_error,
	// endpoint 3 event pulses
	input  wire        ep3_buf0_ready,
	input  wire        ep3_buf1_ready,
	input  wire        ep3_xfer_error,
	// control endpoint 10 event pulses
	input  wire        control_endpoint_10_source_buf_ready,
	input  wire        control_endpoint_10_source_ctl_done,
	input  wire        control_endpoint_10_source_status_stage,
	input  wire        control_endpoint_10_source_setup_ready,
	input  wire        control_endpoint_10_source_ctl_error,
	// endpoint 11 event pulse
	input  wire        endpoint_11_source_buf0_wr_ready,
	// software clears, one per source
	input  wire [6:0]  source_clear,
	// source flags
	output wire        endpoint_1_source,
	output wire        endpoint_2_source,
	output wire        endpoint_3_source,
	output wire        control_endpoint_10_source,
	output wire        endpoint_11_source,
	output wire        suspend_source,
	output wire        resume_source,
	// per-cause detail, same layout as the map header
	output wire [16:0] cause_flags,
	// live bus state after synchronising
	output wire        bus_in_j
);
	// full speed idle: plus line high, minus line low
	function is_j_state;
		input dp;
		input dm;
		begin
			is_j_state = dp & ~dm;
		end
	endfunction

	// narrowed once to the counter width so the compare has matching width
	localparam [`USBI_IDLE_W-1:0] SUSP_LIMIT =
		SUSP_CYCLES[`USBI_IDLE_W-1:0];

	// two stage synchronisers on the pins
	reg        dp_meta_q;
	reg        dp_sync_q;
	reg        dm_meta_q;
	reg        dm_sync_q;
	// bus state history
	reg        was_j_q;
	// suspend idle timer
	reg [`USBI_IDLE_W-1:0] idle_cnt_q;
	reg [`USBI_IDLE_W-1:0] idle_cnt_d;
	reg        susp_done_q;
	reg        susp_done_d;
	reg        susp_hit;

	wire       now_j;
	wire       leave_j;
	wire       resume_hit;
	wire [`USBI_NUM_CAUSES-1:0] set_vec;
	reg  [`USBI_NUM_CAUSES-1:0] clr_vec;
	wire [`USBI_NUM_CAUSES-1:0] flags;
	wire [`USBI_NUM_CAUSES-1:0] flags_d;
	// source levels kept in flip-flops so they never carry gate glitches
	reg  [`USBI_NUM_SOURCES-1:0] src_q;
	reg  [`USBI_NUM_SOURCES-1:0] src_d;

	always @(posedge clk) begin
		if (reset) begin
			dp_meta_q <= 1'h0;
			dp_sync_q <= 1'h0;
			dm_meta_q <= 1'h0;
			dm_sync_q <= 1'h0;
		end else begin
			dp_meta_q <= bus_plus_line;
			dp_sync_q <= dp_meta_q;
			dm_meta_q <= bus_minus_line;
			dm_sync_q <= dm_meta_q;
		end
	end

	assign now_j = is_j_state(dp_sync_q, dm_sync_q);

	always @(posedge clk) begin
		if (reset) begin
			was_j_q <= 1'h0;
		end else begin
			was_j_q <= now_j;
		end
	end

	// j to se0 or k: the minus line rises or the plus line drops
	assign leave_j = was_j_q & ~now_j;

	// resume needs both enables held at the moment of the change
	assign resume_hit = leave_j & usb_module_enable &
		resume_interrupt_enable;

	// idle timer: counts continuous j while enabled, fires once per idle
	// period; a disabled module holds it at zero so no stale count survives
	always @* begin
		idle_cnt_d  = idle_cnt_q;
		susp_done_d = susp_done_q;
		susp_hit    = 1'h0;
		if (!usb_module_enable || !now_j) begin
			idle_cnt_d  = {`USBI_IDLE_W{1'h0}};
			susp_done_d = 1'h0;
		end else if (!susp_done_q) begin
			if (idle_cnt_q == SUSP_LIMIT - 1'h1) begin
				susp_hit    = 1'h1;
				susp_done_d = 1'h1;
				idle_cnt_d  = {`USBI_IDLE_W{1'h0}};
			end else begin
				idle_cnt_d = idle_cnt_q + 1'h1;
			end
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			idle_cnt_q  <= {`USBI_IDLE_W{1'h0}};
			susp_done_q <= 1'h0;
		end else begin
			idle_cnt_q  <= idle_cnt_d;
			susp_done_q <= susp_done_d;
		end
	end

	// gather every cause into one vector
	assign set_vec[`USBI_EP1_LSB +: `USBI_EP_CAUSES] =
		{ep1_xfer_error, ep1_buf1_ready, ep1_buf0_ready};
	assign set_vec[`USBI_EP2_LSB +: `USBI_EP_CAUSES] =
		{ep2_xfer_error, ep2_buf1_ready, ep2_buf0_ready};
	assign set_vec[`USBI_EP3_LSB +: `USBI_EP_CAUSES] =
		{ep3_xfer_error, ep3_buf1_ready, ep3_buf0_ready};
	assign set_vec[`USBI_CONTROL_ENDPOINT_10_SOURCE_LSB +: `USBI_CTL_CAUSES] =
		{control_endpoint_10_source_ctl_error, control_endpoint_10_source_setup_ready, control_endpoint_10_source_status_stage,
		control_endpoint_10_source_ctl_done, control_endpoint_10_source_buf_ready};
	// no read-direction event exists for this endpoint
	assign set_vec[`USBI_ENDPOINT_11_SOURCE_BIT] = endpoint_11_source_buf0_wr_ready;
	assign set_vec[`USBI_SUS_BIT]  = susp_hit;
	assign set_vec[`USBI_RSM_BIT]  = resume_hit;

	// a source clear wipes every cause behind that source
	always @* begin
		clr_vec = {`USBI_NUM_CAUSES{1'h0}};
		clr_vec[`USBI_EP1_LSB +: `USBI_EP_CAUSES] =
			{`USBI_EP_CAUSES{source_clear[`USBI_SRC_EP1]}};
		clr_vec[`USBI_EP2_LSB +: `USBI_EP_CAUSES] =
			{`USBI_EP_CAUSES{source_clear[`USBI_SRC_EP2]}};
		clr_vec[`USBI_EP3_LSB +: `USBI_EP_CAUSES] =
			{`USBI_EP_CAUSES{source_clear[`USBI_SRC_EP3]}};
		clr_vec[`USBI_CONTROL_ENDPOINT_10_SOURCE_LSB +: `USBI_CTL_CAUSES] =
			{`USBI_CTL_CAUSES{source_clear[`USBI_SRC_CONTROL_ENDPOINT_10_SOURCE]}};
		clr_vec[`USBI_ENDPOINT_11_SOURCE_BIT] = source_clear[`USBI_SRC_ENDPOINT_11_SOURCE];
		clr_vec[`USBI_SUS_BIT]  = source_clear[`USBI_SRC_SUS];
		clr_vec[`USBI_RSM_BIT]  = source_clear[`USBI_SRC_RSM];
	end

	usbi_sticky #(
		.W      (`USBI_NUM_CAUSES)
	) u_flags (
		.clk    (clk),
		.reset  (reset),
		.set_in (set_vec),
		.clr_in (clr_vec),
		.flag   (flags)
	);

	// next cause value, the same equation as the sticky bank, so the
	// source levels come from flip-flops without an extra cycle of delay
	assign flags_d = set_vec | (flags & ~clr_vec);

	always @* begin
		src_d = `USBI_SRC_RST;
		src_d[`USBI_SRC_EP1]  =
			|flags_d[`USBI_EP1_LSB +: `USBI_EP_CAUSES];
		src_d[`USBI_SRC_EP2]  =
			|flags_d[`USBI_EP2_LSB +: `USBI_EP_CAUSES];
		src_d[`USBI_SRC_EP3]  =
			|flags_d[`USBI_EP3_LSB +: `USBI_EP_CAUSES];
		src_d[`USBI_SRC_CONTROL_ENDPOINT_10_SOURCE] =
			|flags_d[`USBI_CONTROL_ENDPOINT_10_SOURCE_LSB +: `USBI_CTL_CAUSES];
		src_d[`USBI_SRC_ENDPOINT_11_SOURCE] = flags_d[`USBI_ENDPOINT_11_SOURCE_BIT];
		src_d[`USBI_SRC_SUS]  = flags_d[`USBI_SUS_BIT];
		src_d[`USBI_SRC_RSM]  = flags_d[`USBI_RSM_BIT];
	end

	always @(posedge clk) begin
		if (reset) begin
			src_q <= `USBI_SRC_RST;
		end else begin
			src_q <= src_d;
		end
	end

	assign endpoint_1_source          = src_q[`USBI_SRC_EP1];
	assign endpoint_2_source          = src_q[`USBI_SRC_EP2];
	assign endpoint_3_source          = src_q[`USBI_SRC_EP3];
	assign control_endpoint_10_source = src_q[`USBI_SRC_CONTROL_ENDPOINT_10_SOURCE];
	assign endpoint_11_source         = src_q[`USBI_SRC_ENDPOINT_11_SOURCE];
	assign suspend_source             = src_q[`USBI_SRC_SUS];
	assign resume_source              = src_q[`USBI_SRC_RSM];
	assign cause_flags                = flags;
	assign bus_in_j                   = now_j;
endmodule // usbi_top
`default_nettype wire
